// ==== atf_pkg.sv ====
// Shared constants and types for the task-file status and command front end
`default_nettype none
package atf_pkg;
   // Register offsets on the task-file port
   localparam logic [3:0] ATF_OFF_ERROR = 4'h1;
   localparam logic [3:0] ATF_OFF_ERROR_ALT = 4'hd;
   localparam logic [3:0] ATF_OFF_SEC_CNT = 4'h2;
   localparam logic [3:0] ATF_OFF_SEC_NUM = 4'h3;
   localparam logic [3:0] ATF_OFF_CYL_LO = 4'h4;
   localparam logic [3:0] ATF_OFF_CYL_HI = 4'h5;
   localparam logic [3:0] ATF_OFF_DRV_HEAD = 4'h6;
   localparam logic [3:0] ATF_OFF_STATUS = 4'h7;
   localparam logic [3:0] ATF_OFF_DEV_CTRL = 4'he;
   localparam logic [3:0] ATF_OFF_ADDR_RB = 4'hf;
   // Status byte bit positions
   localparam int ATF_ST_BUSY = 7;
   localparam int ATF_ST_READY = 6;
   localparam int ATF_ST_WF = 5;
   localparam int ATF_ST_SEEK = 4;
   localparam int ATF_ST_XREQ = 3;
   localparam int ATF_ST_FIXED = 2;
   localparam int ATF_ST_INDEX = 1;
   localparam int ATF_ST_ERR = 0;
   // Device control bits
   localparam int ATF_DC_SRST = 2;
   localparam int ATF_DC_NIEN = 1;
   // Drive address readback and drive/head register bits
   localparam int ATF_RB_WRITE_N = 6;
   localparam int ATF_DH_DRV = 4;
   // Error, sector count, power query and drive/head register values
   localparam logic [7:0] ATF_ERR_ABORTED = 8'h04;
   localparam logic [7:0] ATF_DIAG_OK = 8'h01;
   localparam logic [7:0] ATF_SEC_CNT_RESET = 8'h01;
   localparam logic [7:0] ATF_PWR_IDLE = 8'hff;
   localparam logic [7:0] ATF_PWR_STANDBY = 8'h00;
   localparam logic [7:0] ATF_DH_RESET = 8'ha0;
   // Timing
   localparam int ATF_CLK_PS = 5000;
   localparam int ATF_T_BUSY_NS = 400;
   localparam int ATF_T_DRQ2_US = 700;
   localparam int ATF_T_DRQ3_MS = 20;
   localparam int ATF_BUSY_CYC = (ATF_T_BUSY_NS * 1000) / ATF_CLK_PS;
   localparam int ATF_DRQ2_CYC = (ATF_T_DRQ2_US * 1000000) / ATF_CLK_PS;
   localparam int ATF_DRQ3_CYC = ATF_T_DRQ3_MS * (1000000000 / ATF_CLK_PS);
   // Command codes
   localparam logic [7:0] OP_PWR_A = 8'he5, OP_PWR_B = 8'h98, OP_ERASE = 8'hc0,
      OP_DIAG = 8'h90, OP_FLUSH = 8'he7, OP_FORMAT = 8'h50, OP_IDENT = 8'hec,
      OP_IDLE_A = 8'he3, OP_IDLE_B = 8'h97, OP_IDLEI_A = 8'he1, OP_IDLEI_B = 8'h95,
      OP_INIT_PARAM = 8'h91, OP_NOP = 8'h00, OP_RD_BUF = 8'he4, OP_RD_DMA = 8'hc8,
      OP_RD_MULT = 8'hc4, OP_RD_MAX = 8'hf8, OP_RD_A = 8'h20, OP_RD_B = 8'h21,
      OP_RDV_A = 8'h40, OP_RDV_B = 8'h41, OP_SENSE = 8'h03, OP_SEC_DIS = 8'hf6,
      OP_SEC_PREP = 8'hf3, OP_SEC_ERASE = 8'hf4, OP_SEC_FREEZE = 8'hf5,
      OP_SEC_SET = 8'hf1, OP_SEC_UNLOCK = 8'hf2, OP_FEATURES = 8'hef,
      OP_SET_MAX = 8'hf9, OP_SET_MULT = 8'hc6, OP_SLEEP_A = 8'he6, OP_SLEEP_B = 8'h99,
      OP_HEALTH = 8'hb0, OP_STBY_A = 8'he2, OP_STBY_B = 8'h96, OP_STBYI_A = 8'he0,
      OP_STBYI_B = 8'h94, OP_XLATE = 8'h87, OP_WR_BUF = 8'he8, OP_WR_DMA = 8'hca,
      OP_WR_MULT = 8'hc5, OP_WR_MULT_NE = 8'hcd, OP_WR_A = 8'h30, OP_WR_B = 8'h31,
      OP_WR_NE = 8'h38, OP_WR_VERIFY = 8'h3c;
   localparam logic [3:0] OP_HI_RECAL = 4'h1;
   localparam logic [3:0] OP_HI_SEEK = 4'h7;

   typedef enum logic [1:0] {
      ATF_K_MEDIA = 2'b00,
      ATF_K_NOP = 2'b01,
      ATF_K_POWER = 2'b10,
      ATF_K_BAD = 2'b11
   } atf_kind_t;

   typedef enum logic [1:0] {
      ATF_CLS_1 = 2'b01,
      ATF_CLS_2 = 2'b10,
      ATF_CLS_3 = 2'b11
   } atf_class_t;

   typedef enum logic [2:0] {
      ATF_S_IDLE = 3'b000,
      ATF_S_ACCEPT = 3'b001,
      ATF_S_WAIT_BUF = 3'b011,
      ATF_S_XFER = 3'b010,
      ATF_S_EXEC = 3'b110
   } atf_state_t;
endpackage : atf_pkg
`default_nettype wire

// ==== atf_cmd_decode.sv ====
// Command code decoder: kind, acceptance class and head usage
`default_nettype none
module atf_cmd_decode
   import atf_pkg::*;
(
   input wire logic [7:0] i_code,
   output atf_kind_t o_kind,
   output atf_class_t o_class,
   output logic o_drive_only
);
   always_comb begin
      o_kind = ATF_K_MEDIA;
      o_class = ATF_CLS_1;
      o_drive_only = 1'b1;
      // Recalibrate and seek match on the upper nibble alone
      if (i_code[7:4] == OP_HI_RECAL) begin
         o_kind = ATF_K_NOP;
      end else if (i_code[7:4] == OP_HI_SEEK) begin
         o_kind = ATF_K_NOP;
         o_drive_only = 1'b0;
      end else begin
         case (i_code)
            OP_PWR_A, OP_PWR_B: begin
               o_kind = ATF_K_POWER;
            end
            OP_INIT_PARAM: begin
               o_kind = ATF_K_NOP;
               o_drive_only = 1'b0;
            end
            OP_NOP, OP_DIAG, OP_FLUSH, OP_IDENT, OP_IDLE_A, OP_IDLE_B, OP_IDLEI_A,
            OP_IDLEI_B, OP_RD_BUF, OP_RD_MAX, OP_SENSE, OP_SEC_DIS, OP_SEC_PREP,
            OP_SEC_ERASE, OP_SEC_FREEZE, OP_SEC_SET, OP_SEC_UNLOCK, OP_FEATURES,
            OP_SET_MULT, OP_SLEEP_A, OP_SLEEP_B, OP_HEALTH, OP_STBY_A, OP_STBY_B,
            OP_STBYI_A, OP_STBYI_B: begin
               o_kind = ATF_K_MEDIA;
            end
            OP_ERASE, OP_RD_DMA, OP_RD_MULT, OP_RD_A, OP_RD_B, OP_RDV_A, OP_RDV_B,
            OP_SET_MAX, OP_XLATE: begin
               o_drive_only = 1'b0;
            end
            OP_WR_BUF: begin
               o_class = ATF_CLS_2;
            end
            OP_FORMAT, OP_WR_DMA, OP_WR_A, OP_WR_B, OP_WR_NE: begin
               o_class = ATF_CLS_2;
               o_drive_only = 1'b0;
            end
            OP_WR_MULT, OP_WR_MULT_NE, OP_WR_VERIFY: begin
               o_class = ATF_CLS_3;
               o_drive_only = 1'b0;
            end
            default: begin
               o_kind = ATF_K_BAD;
            end
         endcase
      end
   end
endmodule : atf_cmd_decode
`default_nettype wire

// ==== atf_front_end.sv ====
// Task-file status, device control, address readback and command sequencing
//
// How it works
// - Corrected-data flag set; reads keep running
// - Status bit 1 always reads zero
// - Error flag set on failure, cleared by next command
// - Failing sector address left in parameter registers
// - Status packed busy,ready,fault,seek,request,fixed,0,error
// - Device control writable even while busy
// - Soft restart clears status, loads diagnostic code
// - Control bit 1 masks the interrupt request
// - Readback bit 6 low during media write
// - Readback bits 5..2 invert head bits
// - Readback bits 1,0 low for selected unit
// - Class 1: busy within 400 ns
// - Class 2: request within 700 us, busy drops
// - Class 3: request within 20 ms, busy drops
// - Decoder assigns write codes to classes 2, 3
// - Legacy codes complete as no-operation
// - Drive-only commands ignore the head field
// - Power query in standby returns zero count
// - Power query while idle returns FFh count
// - Status read clears pending interrupt; alternate not
// - Aborted bit set for rejected or invalid commands
// - Busy: device owns command and parameter registers
`default_nettype none
module atf_front_end
   import atf_pkg::*;
#(
   parameter int DRQ2_LIMIT = ATF_DRQ2_CYC,
   parameter int DRQ3_LIMIT = ATF_DRQ3_CYC
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   input wire logic [7:0] i_wdata,
   input wire logic i_card_ready,
   input wire logic i_standby,
   input wire logic i_write_active,
   input wire logic i_unit_active,
   input wire logic i_corrected,
   input wire logic i_write_fault,
   input wire logic i_buf_ready,
   input wire logic i_media_done,
   input wire logic i_media_error,
   input wire logic [7:0] i_media_err_bits,
   input wire logic [7:0] i_fail_sec,
   input wire logic [15:0] i_fail_cyl,
   input wire logic [3:0] i_fail_head,
   output logic [7:0] o_rdata,
   output logic o_card_interrupt_request_n,
   output logic o_int_bit,
   output logic o_cmd_start,
   output logic [7:0] o_cmd_code,
   output logic [1:0] o_cmd_class,
   output logic o_cmd_drive,
   output logic [3:0] o_cmd_head
);
   typedef struct packed {
      atf_state_t st;
      logic busy;
      logic xfer_req;
      logic err;
      logic fixed;
      logic wf;
      logic [7:0] err_reg;
      logic srst;
      logic nien;
      logic [7:0] sec_cnt;
      logic [7:0] sec_num;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] drv_head;
      logic irq_pend;
      logic irq_n;
      logic int_bit;
      logic [7:0] rdata;
      logic start;
      logic [7:0] code;
      logic [1:0] cls;
      logic [3:0] head;
      logic [31:0] tmo;
   } atf_regs_t;

   atf_regs_t s_r;
   atf_regs_t s_nxt;
   atf_kind_t dec_kind;
   atf_class_t dec_class;
   logic dec_drive_only;
   logic [7:0] status_byte;
   logic [7:0] readback_byte;
   logic cmd_take;
   logic ready_eff;

   atf_cmd_decode u_decode (
      .i_code(s_r.code),
      .o_kind(dec_kind),
      .o_class(dec_class),
      .o_drive_only(dec_drive_only)
   );

   // Ready and seek-complete are withheld while the controller sits in soft restart
   assign ready_eff = i_card_ready & ~s_r.srst;
   assign status_byte = {s_r.busy, ready_eff, s_r.wf, ready_eff, s_r.xfer_req, s_r.fixed,
                         1'b0, s_r.err};
   assign readback_byte = {1'b0, ~i_write_active, ~s_r.drv_head[3:0],
                           ~(i_unit_active & s_r.drv_head[ATF_DH_DRV]),
                           ~(i_unit_active & ~s_r.drv_head[ATF_DH_DRV])};
   // Commands are taken only when fully idle, so a write during a data phase is dropped
   assign cmd_take = i_wr_stb && (i_addr == ATF_OFF_STATUS) && !s_r.busy && !s_r.srst
                     && (s_r.st == ATF_S_IDLE);

   always_comb begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      // Task parameters are frozen while busy so the device owns them
      if (i_wr_stb && !s_r.busy) begin
         case (i_addr)
            ATF_OFF_SEC_CNT: s_nxt.sec_cnt = i_wdata;
            ATF_OFF_SEC_NUM: s_nxt.sec_num = i_wdata;
            ATF_OFF_CYL_LO: s_nxt.cyl_lo = i_wdata;
            ATF_OFF_CYL_HI: s_nxt.cyl_hi = i_wdata;
            ATF_OFF_DRV_HEAD: s_nxt.drv_head = i_wdata;
            default: begin
            end
         endcase
      end
      // Only bits 2 and 1 matter; the host keeps the rest zero
      if (i_wr_stb && i_addr == ATF_OFF_DEV_CTRL) begin
         s_nxt.srst = i_wdata[ATF_DC_SRST];
         s_nxt.nien = i_wdata[ATF_DC_NIEN];
      end
      // Primary status read clears the pending interrupt; alternate read leaves it
      if (i_rd_stb && i_addr == ATF_OFF_STATUS) begin
         s_nxt.irq_pend = 1'b0;
      end
      if (cmd_take) begin
         s_nxt.code = i_wdata;
         s_nxt.busy = 1'b1;
         s_nxt.err = 1'b0;
         s_nxt.fixed = 1'b0;
         s_nxt.wf = 1'b0;
         s_nxt.xfer_req = 1'b0;
         s_nxt.st = ATF_S_ACCEPT;
      end
      // Flag events come after the command clear, so one in the take cycle is kept
      if (i_corrected) begin
         s_nxt.fixed = 1'b1;
      end
      if (i_write_fault) begin
         s_nxt.wf = 1'b1;
      end
      case (s_r.st)
         ATF_S_IDLE: begin
         end
         ATF_S_ACCEPT: begin
            s_nxt.cls = dec_class;
            s_nxt.head = dec_drive_only ? 4'h0 : s_r.drv_head[3:0];
            s_nxt.tmo = 32'h0;
            case (dec_kind)
               ATF_K_BAD: begin
                  s_nxt.err = 1'b1;
                  s_nxt.err_reg = ATF_ERR_ABORTED;
                  s_nxt.busy = 1'b0;
                  s_nxt.irq_pend = 1'b1;
                  s_nxt.st = ATF_S_IDLE;
               end
               ATF_K_NOP: begin
                  s_nxt.busy = 1'b0;
                  s_nxt.irq_pend = 1'b1;
                  s_nxt.st = ATF_S_IDLE;
               end
               ATF_K_POWER: begin
                  s_nxt.sec_cnt = i_standby ? ATF_PWR_STANDBY : ATF_PWR_IDLE;
                  s_nxt.busy = 1'b0;
                  s_nxt.irq_pend = 1'b1;
                  s_nxt.st = ATF_S_IDLE;
               end
               default: begin
                  s_nxt.start = 1'b1;
                  s_nxt.st = (dec_class == ATF_CLS_1) ? ATF_S_EXEC : ATF_S_WAIT_BUF;
               end
            endcase
         end
         ATF_S_WAIT_BUF: begin
            s_nxt.tmo = s_r.tmo + 32'h1;
            if (i_buf_ready) begin
               // Request and busy swap on one edge, well inside the busy-drop window
               s_nxt.xfer_req = 1'b1;
               s_nxt.busy = 1'b0;
               s_nxt.st = ATF_S_XFER;
            end else if (s_r.tmo >= 32'((s_r.cls == ATF_CLS_3) ? DRQ3_LIMIT - 1
                                                              : DRQ2_LIMIT - 1)) begin
               s_nxt.err = 1'b1;
               s_nxt.err_reg = ATF_ERR_ABORTED;
               s_nxt.busy = 1'b0;
               s_nxt.irq_pend = 1'b1;
               s_nxt.st = ATF_S_IDLE;
            end
         end
         ATF_S_XFER, ATF_S_EXEC: begin
            if (i_media_done) begin
               s_nxt.busy = 1'b0;
               s_nxt.xfer_req = 1'b0;
               s_nxt.irq_pend = 1'b1;
               s_nxt.st = ATF_S_IDLE;
               if (i_media_error) begin
                  s_nxt.err = 1'b1;
                  s_nxt.err_reg = i_media_err_bits;
                  s_nxt.sec_num = i_fail_sec;
                  s_nxt.cyl_lo = i_fail_cyl[7:0];
                  s_nxt.cyl_hi = i_fail_cyl[15:8];
                  s_nxt.drv_head[3:0] = i_fail_head;
               end
            end
         end
         default: begin
            s_nxt.st = ATF_S_IDLE;
         end
      endcase
      // Soft restart overrides state, status flags, interrupt and error register, and holds while the bit stays set
      if (s_r.srst) begin
         s_nxt.st = ATF_S_IDLE;
         s_nxt.busy = 1'b0;
         s_nxt.xfer_req = 1'b0;
         s_nxt.err = 1'b0;
         s_nxt.fixed = 1'b0;
         s_nxt.wf = 1'b0;
         s_nxt.irq_pend = 1'b0;
         s_nxt.start = 1'b0;
         s_nxt.err_reg = ATF_DIAG_OK;
      end
      if (i_rd_stb) begin
         case (i_addr)
            ATF_OFF_ERROR, ATF_OFF_ERROR_ALT: s_nxt.rdata = s_r.err_reg;
            ATF_OFF_SEC_CNT: s_nxt.rdata = s_r.sec_cnt;
            ATF_OFF_SEC_NUM: s_nxt.rdata = s_r.sec_num;
            ATF_OFF_CYL_LO: s_nxt.rdata = s_r.cyl_lo;
            ATF_OFF_CYL_HI: s_nxt.rdata = s_r.cyl_hi;
            ATF_OFF_DRV_HEAD: s_nxt.rdata = s_r.drv_head;
            ATF_OFF_STATUS, ATF_OFF_DEV_CTRL: s_nxt.rdata = status_byte;
            ATF_OFF_ADDR_RB: s_nxt.rdata = readback_byte;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
      s_nxt.irq_n = ~(s_nxt.irq_pend & ~s_nxt.nien);
      s_nxt.int_bit = s_nxt.irq_pend & ~s_nxt.nien;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         s_r <= '0;
         s_r.st <= ATF_S_IDLE;
         s_r.err_reg <= ATF_DIAG_OK;
         s_r.sec_cnt <= ATF_SEC_CNT_RESET;
         s_r.drv_head <= ATF_DH_RESET;
         s_r.irq_n <= 1'b1;
         s_r.cls <= ATF_CLS_1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rdata = s_r.rdata;
   assign o_card_interrupt_request_n = s_r.irq_n;
   assign o_int_bit = s_r.int_bit;
   assign o_cmd_start = s_r.start;
   assign o_cmd_code = s_r.code;
   assign o_cmd_class = s_r.cls;
   assign o_cmd_drive = s_r.drv_head[ATF_DH_DRV];
   assign o_cmd_head = s_r.head;

   localparam int BUSY_LIM = ATF_BUSY_CYC;

   sequence s_take;
      cmd_take;
   endsequence
   sequence s_req_rise;
      !s_r.xfer_req ##1 s_r.xfer_req;
   endsequence

   property p_busy_on_take;
      @(posedge i_clock) disable iff (!i_rst_n)
         s_take |-> ##[1:BUSY_LIM] s_r.busy;
   endproperty
   a_busy_on_take: assert property (p_busy_on_take) else $error("busy late");

   property p_err_cleared;
      @(posedge i_clock) disable iff (!i_rst_n)
         s_take |=> !s_r.err && s_r.fixed == $past(i_corrected)
                    && s_r.wf == $past(i_write_fault);
   endproperty
   a_err_cleared: assert property (p_err_cleared) else $error("error kept");

   property p_index_zero;
      @(posedge i_clock) disable iff (!i_rst_n)
         i_rd_stb && (i_addr == ATF_OFF_STATUS || i_addr == ATF_OFF_DEV_CTRL)
         |=> !o_rdata[ATF_ST_INDEX] && o_rdata[ATF_ST_BUSY] == $past(s_r.busy);
   endproperty
   a_index_zero: assert property (p_index_zero) else $error("status byte bad");

   property p_srst;
      @(posedge i_clock) disable iff (!i_rst_n)
         s_r.srst |=> !s_r.busy && !s_r.err && s_r.err_reg == ATF_DIAG_OK;
   endproperty
   a_srst: assert property (p_srst) else $error("soft restart bad");

   property p_mask;
      @(posedge i_clock) disable iff (!i_rst_n)
         s_r.nien |-> o_card_interrupt_request_n && !o_int_bit;
   endproperty
   a_mask: assert property (p_mask) else $error("masked irq seen");

   property p_readback;
      @(posedge i_clock) disable iff (!i_rst_n)
         i_rd_stb && i_addr == ATF_OFF_ADDR_RB
         |=> o_rdata[5:2] == ~$past(s_r.drv_head[3:0])
             && o_rdata[ATF_RB_WRITE_N] == !$past(i_write_active);
   endproperty
   a_readback: assert property (p_readback) else $error("readback bad");

   property p_power_idle;
      @(posedge i_clock) disable iff (!i_rst_n)
         s_take ##1 (dec_kind == ATF_K_POWER && !i_standby && !s_r.srst)
         |=> s_r.sec_cnt == ATF_PWR_IDLE && !s_r.busy && s_r.irq_pend;
   endproperty
   a_power_idle: assert property (p_power_idle) else $error("power query bad");

   property p_bad_abort;
      @(posedge i_clock) disable iff (!i_rst_n)
         s_take ##1 (dec_kind == ATF_K_BAD && !s_r.srst)
         |=> s_r.err && s_r.err_reg == ATF_ERR_ABORTED && !s_r.busy && !s_r.start;
   endproperty
   a_bad_abort: assert property (p_bad_abort) else $error("bad code not aborted");

   property p_req_busy;
      @(posedge i_clock) disable iff (!i_rst_n)
         s_req_rise |-> ##[0:BUSY_LIM] !s_r.busy;
   endproperty
   a_req_busy: assert property (p_req_busy) else $error("busy held with request");

   property p_stat_rd_clear;
      @(posedge i_clock) disable iff (!i_rst_n)
         i_rd_stb && i_addr == ATF_OFF_STATUS && s_r.st == ATF_S_IDLE && !cmd_take
         |=> !s_r.irq_pend;
   endproperty
   a_stat_rd_clear: assert property (p_stat_rd_clear) else $error("irq not cleared");
endmodule : atf_front_end
`default_nettype wire

// ==== atf_host_model.sv ====
// Host-side model that drives the task-file register port
`default_nettype none
module atf_host_model (
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   output logic [3:0] o_addr,
   output logic o_wr_stb,
   output logic o_rd_stb,
   output logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_addr = 4'h0;
      o_wr_stb = 1'b0;
      o_rd_stb = 1'b0;
      o_wdata = 8'h00;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_addr <= a;
      o_wdata <= (a == 4'he) ? (d & 8'h06) : d;
      o_wr_stb <= 1'b1;
      @(posedge i_clock);
      o_wr_stb <= 1'b0;
      // Released data must not keep its last value
      o_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clock);
      o_addr <= a;
      o_rd_stb <= 1'b1;
      @(posedge i_clock);
      o_rd_stb <= 1'b0;
      #1;
      d = i_rdata;
   endtask : rd
   // Alternate status is polled so that a pending interrupt survives
   task automatic issue(input logic [7:0] dh, input logic [7:0] code);
      logic [7:0] s;
      int n;
      s = 8'h80;
      for (n = 0; n < 50 && s[7]; n++) begin
         rd(4'he, s);
      end
      wr(4'h6, dh);
      wr(4'h7, code);
   endtask : issue
endmodule : atf_host_model
`default_nettype wire

// ==== test_ata_taskfile_status_command_front_end.sv ====
// Self-checking bench for the task-file front end
`default_nettype none
module test_ata_taskfile_status_command_front_end
   import atf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, wr, rd, rdy, stby, wact, uact, fix_ev, wflt, bufr, mdone, merr;
   logic irq_n, int_bit, start, drv;
   logic [3:0] addr, fhead, head;
   logic [7:0] wd, rdat, mbits, fsec, code, r, dh;
   logic [15:0] fcyl;
   logic [1:0] cls, last_cls;
   logic [3:0] last_head;
   logic [7:0] q[$] = '{8'h20, 8'hec, 8'h30, 8'h31, 8'h38, 8'he8, 8'hca, 8'h50, 8'hc5,
      8'hcd, 8'h3c};
   logic [7:0] nops[$] = '{8'h10, 8'h1b, 8'h7e, 8'h91};
   int fails = 0, checks = 0, starts = 0, n0, i;
   integer seed = 32'hd3f34adc;
   atf_front_end #(.DRQ2_LIMIT(20), .DRQ3_LIMIT(40)) dut (.i_clock(clk), .i_rst_n(rst_n),
      .i_addr(addr), .i_wr_stb(wr), .i_rd_stb(rd), .i_wdata(wd), .i_card_ready(rdy),
      .i_standby(stby), .i_write_active(wact), .i_unit_active(uact), .i_corrected(fix_ev),
      .i_write_fault(wflt), .i_buf_ready(bufr), .i_media_done(mdone), .i_media_error(merr),
      .i_media_err_bits(mbits), .i_fail_sec(fsec), .i_fail_cyl(fcyl), .i_fail_head(fhead),
      .o_rdata(rdat), .o_card_interrupt_request_n(irq_n), .o_int_bit(int_bit),
      .o_cmd_start(start), .o_cmd_code(code), .o_cmd_class(cls), .o_cmd_drive(drv),
      .o_cmd_head(head));
   atf_host_model host (.i_clock(clk), .i_rdata(rdat), .o_addr(addr), .o_wr_stb(wr),
      .o_rd_stb(rd), .o_wdata(wd));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (start === 1'b1) begin
         starts++;
         last_cls = cls;
         last_head = head;
      end
   end
   function automatic logic [7:0] exp_class(input logic [7:0] c);
      case (c)
         8'hc5, 8'hcd, 8'h3c: return 8'h03;
         8'h30, 8'h31, 8'h38, 8'he8, 8'hca, 8'h50: return 8'h02;
         default: return 8'h01;
      endcase
   endfunction : exp_class
   task automatic wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic settle;
      int k;
      r = 8'h80;
      for (k = 0; k < 60 && r[7] !== 1'b0; k++) begin
         host.rd(ATF_OFF_DEV_CTRL, r);
      end
      if (r[7] !== 1'b0) begin
         fails++;
         wrap_up();
      end
   endtask : settle
   task automatic wait_start(input int n);
      int k;
      for (k = 0; k < 10 && starts == n; k++) begin
         @(posedge clk);
         #1;
      end
      if (starts == n) begin
         fails++;
         wrap_up();
      end
   endtask : wait_start
   task automatic media_end(input logic e, input logic [7:0] b);
      @(posedge clk);
      mdone <= 1'b1;
      merr <= e;
      mbits <= b;
      @(posedge clk);
      mdone <= 1'b0;
      merr <= ~e;
      mbits <= ~b;
   endtask : media_end
   initial begin
      rst_n = 1'b0;
      rdy = 1'b1;
      {stby, wact, uact, fix_ev, wflt, bufr, mdone, merr} = 8'h00;
      mbits = 8'h00;
      fsec = $random(seed);
      fcyl = $random(seed);
      fhead = $random(seed);
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      host.rd(ATF_OFF_ERROR, r); check(r, ATF_DIAG_OK);
      host.rd(ATF_OFF_SEC_CNT, r); check(r, ATF_SEC_CNT_RESET);
      host.rd(ATF_OFF_DEV_CTRL, r); check(r, 8'h50);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         dh = {3'b101, 5'($random(seed))};
         @(posedge clk);
         wact <= $random(seed);
         uact <= $random(seed);
         host.wr(ATF_OFF_DRV_HEAD, dh);
         host.rd(ATF_OFF_ADDR_RB, r);
         check(r & 8'h7f, {1'b0, ~wact, ~dh[3:0], ~(uact & dh[4]), ~(uact & ~dh[4])});
      end
      $display("test readback done");
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         stby <= i[1];
         host.issue(8'ha0, i[0] ? 8'he5 : 8'h98);
         settle();
         host.rd(ATF_OFF_SEC_CNT, r); check(r, i[1] ? 8'h00 : 8'hff);
         check({7'h0, irq_n}, 8'h00);
         host.rd(ATF_OFF_STATUS, r); check(r, 8'h50);
         check({7'h0, irq_n}, 8'h01);
      end
      $display("test power query done");
      host.issue(8'ha0, 8'hff);
      settle();
      host.rd(ATF_OFF_STATUS, r); check(r, 8'h51);
      host.rd(ATF_OFF_ERROR, r); check(r, ATF_ERR_ABORTED);
      n0 = starts;
      foreach (nops[i]) begin
         host.issue(8'ha0, nops[i]);
         settle();
         host.rd(ATF_OFF_STATUS, r); check(r, 8'h50);
      end
      check(8'(starts - n0), 8'h00);
      $display("test decode done");
      foreach (q[i]) begin
         dh = {3'b101, 5'($random(seed))};
         n0 = starts;
         host.issue(dh, q[i]);
         host.rd(ATF_OFF_DEV_CTRL, r); check(r & 8'h80, 8'h80);
         wait_start(n0);
         check({6'h0, last_cls}, exp_class(q[i]));
         check({4'h0, last_head}, (q[i] inside {8'hec, 8'he8}) ? 8'h00 : {4'h0, dh[3:0]});
         check(code, q[i]);
         check({7'h0, drv}, {7'h0, dh[4]});
         if (exp_class(q[i]) != 8'h01) begin
            @(posedge clk);
            bufr <= 1'b1;
            @(posedge clk);
            bufr <= 1'b0;
            host.rd(ATF_OFF_DEV_CTRL, r); check(r, 8'h58);
         end
         media_end(1'b0, 8'h00);
         settle();
         host.rd(ATF_OFF_STATUS, r); check(r, 8'h50);
      end
      $display("test classes done");
      host.issue(8'ha0, 8'h20);
      repeat (3) @(posedge clk);
      {fix_ev, wflt} <= 2'b11;
      @(posedge clk);
      {fix_ev, wflt} <= 2'b00;
      media_end(1'b1, 8'h40);
      settle();
      host.rd(ATF_OFF_STATUS, r); check(r, 8'h75);
      host.rd(ATF_OFF_ERROR, r); check(r, 8'h40);
      host.rd(ATF_OFF_SEC_NUM, r); check(r, fsec);
      host.rd(ATF_OFF_CYL_LO, r); check(r, fcyl[7:0]);
      host.rd(ATF_OFF_CYL_HI, r); check(r, fcyl[15:8]);
      host.rd(ATF_OFF_DRV_HEAD, r); check(r, {4'ha, fhead});
      host.issue(8'ha0, 8'hc5);
      settle();
      host.rd(ATF_OFF_STATUS, r); check(r, 8'h51);
      $display("test media errors done");
      host.issue(8'ha0, 8'h20);
      host.wr(ATF_OFF_SEC_NUM, ~fsec);
      host.wr(ATF_OFF_DEV_CTRL, 8'hfc);
      host.rd(ATF_OFF_STATUS, r); check(r, 8'h00);
      host.rd(ATF_OFF_ERROR, r); check(r, ATF_DIAG_OK);
      host.rd(ATF_OFF_SEC_NUM, r); check(r, fsec);
      host.wr(ATF_OFF_DEV_CTRL, 8'h02);
      host.issue(8'ha0, 8'h10);
      settle();
      check({6'h0, irq_n, int_bit}, 8'h02);
      host.wr(ATF_OFF_DEV_CTRL, 8'h00);
      @(posedge clk);
      #1;
      check({6'h0, irq_n, int_bit}, 8'h01);
      host.rd(ATF_OFF_STATUS, r); check(r, 8'h50);
      $display("test restart and mask done");
      wrap_up();
   end
endmodule : test_ata_taskfile_status_command_front_end
`default_nettype wire
